// file: verilog/bpe_pkg.sv
// constants and types for the bridge parity error signalling block
// Operation
// - secondary PERR only as secondary write target/read initiator
// - secondary PERR needs secondary response enable
// - downstream read, upstream posted write: secondary enable only
// - upstream delayed write primary error needs both enables
// - downstream delayed write: primary PERR, secondary error needs both enables
// - SERR considered for posted write parity errors
// - no SERR when detected as posted write target
// - posted write SERR needs both response enables
// - SERR also needs SERR enable bit
// - primary PERR only as primary target/initiator, enabled
// - driving SERR sets signalled system error flag
package bpe_pkg;

  // register byte addresses on the wishbone slave
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_STATUS = 8'h04;
  localparam logic [7:0]  ADDR_MASK   = 8'h08;

  // control register fields
  localparam int          CTRL_PRI_PERR_EN = 0;
  localparam int          CTRL_SERR_EN     = 1;
  localparam int          CTRL_SEC_PERR_EN = 2;
  localparam logic [2:0]  CTRL_RESET       = 3'h0;

  // status and mask register fields
  localparam int          STAT_SIG_SERR = 0;
  localparam int          STAT_PRI_PERR = 1;
  localparam int          STAT_SEC_PERR = 2;
  localparam logic [2:0]  STAT_RESET    = 3'h0;
  localparam logic [2:0]  MASK_RESET    = 3'h0;

  // cycles a PERR output stays low, and the high cycle before release
  localparam int          PERR_LOW_CYC  = 1;
  localparam int          PERR_HIGH_CYC = 1;

  typedef enum logic [1:0] {
    XFER_READ,
    XFER_POSTED,
    XFER_DELAYED
  } bpe_xfer_t;

endpackage

// file: verilog/bpe_decode.sv
// decision table: which parity and system error outputs a parity event drives
`timescale 1ns/10ps
`default_nettype none
module bpe_decode
  import bpe_pkg::*;
(
  input  wire logic [1:0] evtKind,
  input  wire logic       evtDown,
  input  wire logic       evtOnSec,
  input  wire logic       evtSelfTgt,
  input  wire logic       priEn,
  input  wire logic       secEn,
  input  wire logic       serrEn,
  output logic            drvPriPerr,
  output logic            drvSecPerr,
  output logic            drvSerr
);

  logic isRead;
  logic isPosted;
  logic isDelayed;

  always_comb begin
    isRead    = (evtKind == 2'(XFER_READ));
    isPosted  = (evtKind == 2'(XFER_POSTED));
    isDelayed = (evtKind == 2'(XFER_DELAYED));
  end

  // primary side: target of write or initiator of read there
  always_comb begin
    drvPriPerr = 1'b0;
    if (priEn) begin
      if (isRead && !evtDown && !evtOnSec)
        drvPriPerr = 1'b1;
      else if (isPosted && evtDown && !evtOnSec)
        drvPriPerr = 1'b1;
      else if (isDelayed && evtDown && !evtOnSec)
        drvPriPerr = 1'b1;
      else if (isDelayed && evtDown && evtOnSec && secEn)
        drvPriPerr = 1'b1;
    end
  end

  // secondary side mirrors the primary with direction swapped
  always_comb begin
    drvSecPerr = 1'b0;
    if (secEn) begin
      if (isRead && evtDown && evtOnSec)
        drvSecPerr = 1'b1;
      else if (isPosted && !evtDown && evtOnSec)
        drvSecPerr = 1'b1;
      else if (isDelayed && !evtDown && evtOnSec)
        drvSecPerr = 1'b1;
      else if (isDelayed && !evtDown && !evtOnSec && priEn)
        drvSecPerr = 1'b1;
    end
  end

  // only posted writes, seen on the far (target) bus, raise SERR
  always_comb begin
    drvSerr = 1'b0;
    if (isPosted && !evtSelfTgt && priEn && secEn && serrEn) begin
      if (evtDown && evtOnSec)
        drvSerr = 1'b1;
      else if (!evtDown && !evtOnSec)
        drvSerr = 1'b1;
    end
  end

endmodule
`default_nettype wire

// file: verilog/bpe_wb_regs.sv
// classic wishbone slave holding control and mask, reading back status
`timescale 1ns/10ps
`default_nettype none
module bpe_wb_regs
  import bpe_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [2:0]  statusIn,
  output logic [2:0]       ctrlOut,
  output logic [2:0]       maskOut,
  output logic             statusRdClr
);

  logic        ack_ff;
  logic [31:0] rdat_ff;
  logic [2:0]  ctrl_ff;
  logic [2:0]  mask_ff;
  logic        access;

  // one wait state: ack rises the cycle after the request, drops after one
  always_comb access = wb_cyc_i && wb_stb_i && !ack_ff;

  always_ff @(posedge clock) begin
    if (!rst_n)
      ack_ff <= 1'b0;
    else
      ack_ff <= access;
  end

  // writes land on the ack edge; only byte lane 0 carries fields
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_ff <= CTRL_RESET;
      mask_ff <= MASK_RESET;
    end else if (access && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == ADDR_CTRL)
        ctrl_ff <= wb_dat_i[2:0];
      if (wb_adr_i == ADDR_MASK)
        mask_ff <= wb_dat_i[2:0];
    end
  end

  // unmapped reads return zero, unmapped writes are dropped
  always_ff @(posedge clock) begin
    if (!rst_n)
      rdat_ff <= 32'h0;
    else if (access && !wb_we_i) begin
      unique case (wb_adr_i)
        ADDR_CTRL:   rdat_ff <= {29'h0, ctrl_ff};
        ADDR_STATUS: rdat_ff <= {29'h0, statusIn};
        ADDR_MASK:   rdat_ff <= {29'h0, mask_ff};
        default:     rdat_ff <= 32'h0;
      endcase
    end
  end

  // status snapshot taken now is the value cleared
  always_comb statusRdClr = access && !wb_we_i && (wb_adr_i == ADDR_STATUS);

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign ctrlOut  = ctrl_ff;
  assign maskOut  = mask_ff;

endmodule
`default_nettype wire

// file: verilog/bpe_parity_signal.sv
// top of the bridge parity error signalling block
//
// Implementation choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module bpe_parity_signal
  import bpe_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  // wishbone register port
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // parity event from the bridge core, same clock
  input  wire logic        evtValid,
  input  wire logic [1:0]  evtKind,
  input  wire logic        evtDown,
  input  wire logic        evtOnSec,
  input  wire logic        evtSelfTgt,
  // pin drives: active low level and output enable
  output logic             priPerrOutN,
  output logic             priPerrOe,
  output logic             secPerrOutN,
  output logic             secPerrOe,
  output logic             priSerrOutN,
  output logic             priSerrOe,
  output logic             irq
);

  logic [2:0] ctrlReg;
  logic [2:0] maskReg;
  logic       statusRdClr;
  logic       drvPriPerr;
  logic       drvSecPerr;
  logic       drvSerr;
  logic       hitPri;
  logic       hitSec;
  logic       hitSerr;

  logic       priPerrN_ff;
  logic       priPerrOe_ff;
  logic       secPerrN_ff;
  logic       secPerrOe_ff;
  logic       serrOe_ff;
  logic [2:0] status_ff;
  logic [2:0] nxt_status;
  logic       irq_ff;

  bpe_wb_regs u_regs (
    .clock       (clock),
    .rst_n       (rst_n),
    .wb_cyc_i    (wb_cyc_i),
    .wb_stb_i    (wb_stb_i),
    .wb_we_i     (wb_we_i),
    .wb_adr_i    (wb_adr_i),
    .wb_sel_i    (wb_sel_i),
    .wb_dat_i    (wb_dat_i),
    .wb_dat_o    (wb_dat_o),
    .wb_ack_o    (wb_ack_o),
    .statusIn    (status_ff),
    .ctrlOut     (ctrlReg),
    .maskOut     (maskReg),
    .statusRdClr (statusRdClr)
  );

  bpe_decode u_decode (
    .evtKind    (evtKind),
    .evtDown    (evtDown),
    .evtOnSec   (evtOnSec),
    .evtSelfTgt (evtSelfTgt),
    .priEn      (ctrlReg[CTRL_PRI_PERR_EN]),
    .secEn      (ctrlReg[CTRL_SEC_PERR_EN]),
    .serrEn     (ctrlReg[CTRL_SERR_EN]),
    .drvPriPerr (drvPriPerr),
    .drvSecPerr (drvSecPerr),
    .drvSerr    (drvSerr)
  );

  always_comb begin
    hitPri  = evtValid && drvPriPerr;
    hitSec  = evtValid && drvSecPerr;
    hitSerr = evtValid && drvSerr;
  end

  // PERR is sustained tri-state: low one cycle, high one cycle, then released
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      priPerrN_ff  <= 1'b1;
      priPerrOe_ff <= 1'b0;
    end else begin
      priPerrN_ff  <= !hitPri;
      priPerrOe_ff <= hitPri || !priPerrN_ff;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      secPerrN_ff  <= 1'b1;
      secPerrOe_ff <= 1'b0;
    end else begin
      secPerrN_ff  <= !hitSec;
      secPerrOe_ff <= hitSec || !secPerrN_ff;
    end
  end

  // SERR is open drain: enable alone pulls the wire low for one cycle
  always_ff @(posedge clock) begin
    if (!rst_n)
      serrOe_ff <= 1'b0;
    else
      serrOe_ff <= hitSerr;
  end

  // set wins over the read clear so no event is lost
  always_comb begin
    nxt_status = status_ff & ~{3{statusRdClr}};
    nxt_status[STAT_SIG_SERR] = nxt_status[STAT_SIG_SERR] | hitSerr;
    nxt_status[STAT_PRI_PERR] = nxt_status[STAT_PRI_PERR] | hitPri;
    nxt_status[STAT_SEC_PERR] = nxt_status[STAT_SEC_PERR] | hitSec;
  end

  always_ff @(posedge clock) begin
    if (!rst_n)
      status_ff <= STAT_RESET;
    else
      status_ff <= nxt_status;
  end

  always_ff @(posedge clock) begin
    if (!rst_n)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(nxt_status & maskReg);
  end

  assign priPerrOutN = priPerrN_ff;
  assign priPerrOe   = priPerrOe_ff;
  assign secPerrOutN = secPerrN_ff;
  assign secPerrOe   = secPerrOe_ff;
  assign priSerrOutN = 1'b0;
  assign priSerrOe   = serrOe_ff;
  assign irq         = irq_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // helper decode of the current event kind; the assertions take its $past
  logic isPostedEvt;
  always_comb isPostedEvt = (evtKind == 2'(XFER_POSTED));

  sec_perr_enable_a: assert property (
    !secPerrN_ff |-> $past(ctrlReg[CTRL_SEC_PERR_EN]))
    else $error("secondary PERR driven without secondary enable");

  sec_perr_role_a: assert property (
    !secPerrN_ff |-> $past(evtValid) &&
      (($past(evtKind) == 2'(XFER_READ)) == $past(evtDown)))
    else $error("secondary PERR outside write target or read initiator role");

  // a new event may land in the high cycle and pull the line low again
  sec_perr_read_a: assert property (
    evtValid && evtKind == 2'(XFER_READ) && evtDown && evtOnSec &&
      ctrlReg[CTRL_SEC_PERR_EN] |=> !secPerrN_ff && secPerrOe_ff
      ##1 secPerrOe_ff && (secPerrN_ff || $past(hitSec))
      ##1 (!secPerrOe_ff || !secPerrN_ff || $past(hitSec, 2)))
    else $error("downstream read secondary error not signalled");

  sec_perr_posted_a: assert property (
    evtValid && evtKind == 2'(XFER_POSTED) && !evtDown && evtOnSec &&
      ctrlReg[CTRL_SEC_PERR_EN] |=> !secPerrN_ff && secPerrOe_ff)
    else $error("upstream posted write secondary error not signalled");

  pri_perr_read_a: assert property (
    evtValid && evtKind == 2'(XFER_READ) && !evtDown && !evtOnSec &&
      ctrlReg[CTRL_PRI_PERR_EN] |=> !priPerrN_ff && priPerrOe_ff)
    else $error("upstream read primary error not signalled");

  pri_perr_posted_a: assert property (
    evtValid && evtKind == 2'(XFER_POSTED) && evtDown && !evtOnSec &&
      ctrlReg[CTRL_PRI_PERR_EN] |=> !priPerrN_ff && priPerrOe_ff)
    else $error("downstream posted write primary error not signalled");

  sec_perr_role_bus_a: assert property (
    !secPerrN_ff |-> $past(evtOnSec) || ($past(evtKind) == 2'(XFER_DELAYED)))
    else $error("secondary PERR for an error seen only on the primary bus");

  irq_level_a: assert property (
    ##1 irq == |($past(nxt_status) & $past(maskReg)))
    else $error("interrupt level does not follow unmasked status");

  serr_flag_set_a: assert property (
    hitSerr |=> status_ff[STAT_SIG_SERR])
    else $error("system error event did not set its status flag");

  sec_perr_dwr_a: assert property (
    evtValid && evtKind == 2'(XFER_DELAYED) && !evtDown && !evtOnSec &&
      ctrlReg[CTRL_SEC_PERR_EN] |=> secPerrN_ff == !$past(ctrlReg[CTRL_PRI_PERR_EN]))
    else $error("upstream delayed write secondary PERR enable mismatch");

  pri_perr_dwr_a: assert property (
    evtValid && evtKind == 2'(XFER_DELAYED) && evtDown && ctrlReg[CTRL_PRI_PERR_EN] |=>
      priPerrN_ff == ($past(evtOnSec) && !$past(ctrlReg[CTRL_SEC_PERR_EN])))
    else $error("downstream delayed write primary PERR wrong");

  pri_perr_enable_a: assert property (
    !priPerrN_ff |-> $past(ctrlReg[CTRL_PRI_PERR_EN]) && $past(evtValid))
    else $error("primary PERR driven without primary enable");

  serr_posted_a: assert property (
    priSerrOe |-> $past(isPostedEvt) && $past(evtValid) &&
      ($past(evtDown) == $past(evtOnSec)))
    else $error("SERR raised for a non posted or wrong bus event");

  serr_self_tgt_a: assert property (
    evtValid && evtSelfTgt |=> !priSerrOe)
    else $error("SERR raised for an error seen as posted write target");

  serr_enables_a: assert property (
    priSerrOe |-> $past(ctrlReg) == 3'h7)
    else $error("SERR raised without both response enables and SERR enable");

  serr_flag_a: assert property (
    priSerrOe |-> status_ff[STAT_SIG_SERR])
    else $error("SERR driven without signalled system error flag");

  quiet_outputs_a: assert property (
    !evtValid |=> priPerrN_ff && secPerrN_ff && !priSerrOe)
    else $error("output asserted without a parity event");

  perr_release_a: assert property (
    $rose(priPerrN_ff) |-> priPerrOe_ff ##1 (!priPerrOe_ff || !priPerrN_ff))
    else $error("primary PERR not driven high before release");

  cov_pri_perr_c: cover property (!priPerrN_ff);
  cov_sec_perr_c: cover property (!secPerrN_ff);
  cov_serr_c:     cover property (priSerrOe ##1 irq);
  cov_clr_c:      cover property (statusRdClr && evtValid);
  cov_rearm_c:    cover property (hitSec ##1 hitSec);

endmodule
`default_nettype wire

// file: verif/bpe_evt_src.sv
// behavioural source of parity events standing in for the bridge core
`timescale 1ns/10ps
`default_nettype none
module bpe_evt_src (
  input  wire logic       clock,
  output logic            evtValid,
  output logic [1:0]      evtKind,
  output logic            evtDown,
  output logic            evtOnSec,
  output logic            evtSelfTgt
);
  initial begin
    evtValid   = 1'b0;
    evtKind    = 2'h0;
    evtDown    = 1'b0;
    evtOnSec   = 1'b0;
    evtSelfTgt = 1'b0;
  end

  // one-cycle pulse; fields invert afterwards so stale values never look valid
  task automatic send(input logic [1:0] k, input logic dn, input logic sec, input logic slf);
    evtValid <= 1'b1;
    evtKind <= k;
    evtDown <= dn;
    evtOnSec <= sec;
    evtSelfTgt <= slf;
    @(posedge clock);
    evtValid <= 1'b0;
    {evtKind, evtDown, evtOnSec, evtSelfTgt} <= ~{k, dn, sec, slf};
  endtask
endmodule
`default_nettype wire

// file: verif/tb_bridge_parity_error_signaling.sv
// self-checking bench for the parity error signalling block
`timescale 1ns/10ps
`default_nettype none
module tb_bridge_parity_error_signaling;
  import bpe_pkg::*;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        wbCyc = 1'b0;
  logic        wbStb = 1'b0;
  logic        wbWe  = 1'b0;
  logic [7:0]  wbAdr = 8'h00;
  logic [3:0]  wbSel = 4'h0;
  logic [31:0] wbDat = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        evtValid, evtDown, evtOnSec, evtSelfTgt;
  logic [1:0]  evtKind;
  logic        priPerrOutN, priPerrOe, secPerrOutN, secPerrOe, priSerrOutN, priSerrOe, irq;
  logic [31:0] rdQ[$];
  logic [3:0]  evQ[$];
  logic [3:0]  expEv;
  logic [2:0]  seenSt = 3'h0;
  int          errCount = 0;
  int          nCompared = 0;

  always #5 clock = ~clock;

  bpe_evt_src src (.clock(clock), .evtValid(evtValid), .evtKind(evtKind), .evtDown(evtDown),
    .evtOnSec(evtOnSec), .evtSelfTgt(evtSelfTgt));

  bpe_parity_signal uut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .evtValid(evtValid), .evtKind(evtKind), .evtDown(evtDown),
    .evtOnSec(evtOnSec), .evtSelfTgt(evtSelfTgt), .priPerrOutN(priPerrOutN), .priPerrOe(priPerrOe),
    .secPerrOutN(secPerrOutN), .secPerrOe(secPerrOe), .priSerrOutN(priSerrOutN),
    .priSerrOe(priSerrOe), .irq(irq));

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", errCount, nCompared);
    if (errCount == 0 && nCompared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // classic single cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDat <= d;
    wbSel <= s;
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    rdQ.push_back(exp);
    wb(1'b0, a, 32'h0, 4'hf);
  endtask

  // expected {priPerr, secPerr, serr}; ctrl bit0 pri enable, bit1 serr enable, bit2 sec enable
  function automatic logic [2:0] ref_out(input logic [1:0] k, input logic dn, input logic sec,
                                         input logic slf, input logic [2:0] c);
    logic p, s, e;
    p = c[0] && ((k == 2'h0 && !dn && !sec) || (k == 2'h1 && dn && !sec)
                 || (k == 2'h2 && dn && (!sec || c[2])));
    s = c[2] && ((k == 2'h0 && dn && sec) || (k == 2'h1 && !dn && sec)
                 || (k == 2'h2 && !dn && (sec || c[0])));
    e = c[0] && c[2] && c[1] && !slf && k == 2'h1 && (dn == sec);
    return {p, s, e};
  endfunction

  always @(posedge clock) begin
    if (wb_ack_o === 1'b1 && !wbWe) begin
      check("rdata", wb_dat_o, rdQ.pop_front());
    end
    if (seenSt[0]) begin
      expEv = evQ.pop_front();
      check("pins", {28'h0, ~priPerrOutN & priPerrOe, ~secPerrOutN & secPerrOe, priSerrOe, irq},
            {28'h0, expEv});
      check("serr_level", {31'h0, priSerrOutN}, 32'h0);
    end
    if (seenSt[1]) begin
      check("high_cycle", {27'h0, priPerrOutN, priPerrOe, secPerrOutN, secPerrOe, priSerrOe},
            {27'h0, 1'b1, expEv[3], 1'b1, expEv[2], 1'b0});
    end
    if (seenSt[2]) begin
      check("released", {30'h0, priPerrOe, secPerrOe}, 32'h0);
    end
    seenSt <= {seenSt[1:0], evtValid & rst_n};
  end

  initial begin
    repeat (20000) @(posedge clock);
    errCount++;
    give_verdict();
  end

  initial begin
    logic [2:0] e;
    logic [2:0] m;
    void'($urandom(36));
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(ADDR_CTRL, {29'h0, CTRL_RESET});
    rd(ADDR_STATUS, {29'h0, STAT_RESET});
    rd(ADDR_MASK, {29'h0, MASK_RESET});
    rd(8'h0c, 32'h0);
    wb(1'b1, ADDR_STATUS, 32'h7, 4'hf);
    rd(ADDR_STATUS, 32'h0);
    wb(1'b1, ADDR_CTRL, 32'h7, 4'he);
    rd(ADDR_CTRL, 32'h0);
    // every kind, direction, bus, enable set and self-target flag
    for (int i = 0; i < 256; i++) begin
      m = 3'($urandom());
      wb(1'b1, ADDR_CTRL, {29'h0, i[2:0]}, 4'h1);
      wb(1'b1, ADDR_MASK, {29'h0, m}, 4'h1);
      e = ref_out(i[4:3], i[5], i[6], i[7], i[2:0]);
      evQ.push_back({e, |({e[1], e[2], e[0]} & m)});
      src.send(i[4:3], i[5], i[6], i[7]);
      repeat (3) @(posedge clock);
      rd(ADDR_STATUS, {29'h0, e[1], e[2], e[0]});
    end
    repeat (2) @(posedge clock);
    check("irq_after_clear", {31'h0, irq}, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
